/* tlic_ctrl.sv */
// Purpose: three-level interrupt arbiter with an AXI4-Lite register file
// Assumes: source inputs synchronous to aclk, active high
// Notes:   core pulses core_ack when it takes the vector, core_done on return
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [R1] Pending requests are arbitrated over three levels: shared auxiliary on top, others high or low by their priority bit.
// [R2] Each standard source has its own flag, enable, vector and priority bit, external 2 to 5 using flag bits 4 to 7 and enable and priority bits 0 to 3.
// [R3] Nine auxiliary sources share one top-level request at vector 33h, number 6, with no priority control.
// [R4] Any enabled auxiliary source sets the shared flag at bit 4 of the extended control register, taken only when its gate at bit 5 is set.
// [R5] Auxiliary enables sit at bits 0 to 7 in the given source order, and the breakpoint is enabled by breakpoint control bit 0.
// [R6] The global gate at bit 7 of the enable register blocks all standard sources when clear.
// [R7] Standard vectors run 03h to 63h in polling order 1 to 12, watchdog last.
// [R8] Edge-mode flags of external 0 and 1 clear when their vector is taken; level-mode flags follow the pin.
// [R9] Timer 0 and timer 1 overflow flags clear when their vector is taken.
// [R10] The timer 1 overflow vector is 1Bh.
module tlic_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [tlic_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tlic_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire tlic_pkg::tlic_src_type src,
	output tlic_pkg::tlic_core_type core,
	input wire logic core_ack,
	input wire logic core_done
);
	import tlic_pkg::*;

	typedef struct packed {
		logic [7:0] irq_en;
		logic [6:0] prio;
		logic [4:0] ext_en;
		logic [4:0] ext_prio;
		logic [3:0] ext_flag;
		logic [7:0] tmr_ctl;
		logic aux_gate;
		logic aux_flag;
		logic wdt_flag;
		logic [7:0] aux_en;
		logic bp_en;
		logic [5:0] pin_prev;
		logic [2:0] in_service;
		tlic_core_type core;
		logic [3:0] sel;
		logic awv;
		logic [AXI_AW-1:0] awaddr;
		logic wv;
		logic [7:0] wdata;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} tlic_state_type;

	tlic_state_type s_r;
	tlic_state_type s_nxt;

	logic [NUM_STD-1:0] flags;
	logic [NUM_STD-1:0] enables;
	logic [NUM_STD-1:0] prio_bits;
	logic [NUM_STD-1:0] pend;
	logic [5:0] pins;
	logic [5:0] rise;
	logic cand_v;
	logic [3:0] cand_idx;
	tlic_level_type cand_lvl;
	logic [2:0] above_mask;
	logic blocked;
	logic do_wr;
	logic rd_hit;
	logic [7:0] rd_val;
	logic wr_hit;
	logic ack_now;

	// handshakes stall with the clock enable so no transfer is lost
	assign s_axi_awready = ce & ~s_r.awv;
	assign s_axi_wready = ce & ~s_r.wv;
	assign s_axi_arready = ce & ~s_r.rvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = {24'h000000, s_r.rdata};
	assign core = s_r.core;

	assign pins = {src.ext_edge_pin, src.ext_lvl_pin};
	assign rise = pins & ~s_r.pin_prev;
	assign ack_now = core_ack & s_r.core.req;

	// [R2] per-source flag, enable, priority
	assign flags = {s_r.wdt_flag, s_r.ext_flag, src.ser1_flag,
		src.tmr2_flag, src.ser0_flag, s_r.tmr_ctl[TMR1_FLAG_BIT],
		s_r.tmr_ctl[EXT1_FLAG_BIT], s_r.tmr_ctl[TMR0_FLAG_BIT],
		s_r.tmr_ctl[EXT0_FLAG_BIT]};
	// [R6] global gate on standard sources
	assign enables = {s_r.ext_en, s_r.irq_en[6:0]} &
		{NUM_STD{s_r.irq_en[GLOBAL_GATE_BIT]}};
	assign prio_bits = {s_r.ext_prio, s_r.prio};
	assign pend = flags & enables;

	// [R1] three-level pick, polling order
	always_comb begin
		logic found_hi;
		logic found_lo;
		logic [3:0] hi_idx;
		logic [3:0] lo_idx;
		found_hi = 1'b0;
		found_lo = 1'b0;
		hi_idx = 4'h0;
		lo_idx = 4'h0;
		for (int i = 0; i < NUM_STD; i++) begin
			if (pend[i] && prio_bits[i] && !found_hi) begin
				found_hi = 1'b1;
				hi_idx = 4'(i);
			end
			if (pend[i] && !prio_bits[i] && !found_lo) begin
				found_lo = 1'b1;
				lo_idx = 4'(i);
			end
		end
		// [R3] shared request sits above all
		if (s_r.aux_flag && s_r.aux_gate) begin
			cand_v = 1'b1;
			cand_idx = IDX_AUX;
			cand_lvl = LVL_AUX;
		end else if (found_hi) begin
			cand_v = 1'b1;
			cand_idx = hi_idx;
			cand_lvl = LVL_HIGH;
		end else begin
			cand_v = found_lo;
			cand_idx = lo_idx;
			cand_lvl = LVL_LOW;
		end
	end

	// [R1] only a higher level preempts
	always_comb begin
		unique case (cand_lvl)
			LVL_LOW: above_mask = 3'h7;
			LVL_HIGH: above_mask = 3'h6;
			LVL_AUX: above_mask = 3'h4;
			default: above_mask = 3'h7;
		endcase
	end
	assign blocked = |(s_r.in_service & above_mask);

	always_comb begin
		rd_hit = 1'b1;
		unique case (s_r.awaddr)
			OFF_IRQ_ENABLE, OFF_PRIO_SELECT, OFF_EXT_ENABLE, OFF_EXT_PRIO,
			OFF_EXT_FLAG, OFF_TMR_CTL, OFF_EXT_IRQ_CTL, OFF_AUX_ENABLE,
			OFF_BP_CTL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		rd_val = 8'h00;
		unique case (s_axi_araddr)
			OFF_IRQ_ENABLE: rd_val = s_r.irq_en;
			OFF_PRIO_SELECT: rd_val = {1'b0, s_r.prio};
			OFF_EXT_ENABLE: rd_val = {3'h0, s_r.ext_en};
			OFF_EXT_PRIO: rd_val = {3'h0, s_r.ext_prio};
			OFF_EXT_FLAG: rd_val = {s_r.ext_flag, 4'h0} | EXT_FLAG_FIXED;
			OFF_TMR_CTL: rd_val = s_r.tmr_ctl;
			OFF_EXT_IRQ_CTL: rd_val = {2'h0, s_r.aux_gate, s_r.aux_flag,
				s_r.wdt_flag, 3'h0};
			OFF_AUX_ENABLE: rd_val = s_r.aux_en;
			OFF_BP_CTL: rd_val = {7'h00, s_r.bp_en};
			OFF_STATUS: rd_val = {s_r.core.req, 4'h0, s_r.in_service};
			default: rd_hit = 1'b0;
		endcase
	end

	assign do_wr = s_r.awv & s_r.wv & ~s_r.bvalid;

	always_comb begin
		s_nxt = s_r;
		// bus capture: address and data may come in either order
		if (s_axi_awvalid && !s_r.awv) begin
			s_nxt.awv = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.wv) begin
			s_nxt.wv = 1'b1;
			s_nxt.wdata = s_axi_wdata[7:0];
			s_nxt.wstb = s_axi_wstrb[0];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			s_nxt.awv = 1'b0;
			s_nxt.wv = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (s_r.wstb && wr_hit) begin
				unique case (s_r.awaddr)
					OFF_IRQ_ENABLE: s_nxt.irq_en = s_r.wdata;
					OFF_PRIO_SELECT: s_nxt.prio = s_r.wdata[6:0];
					OFF_EXT_ENABLE: s_nxt.ext_en = s_r.wdata[4:0];
					OFF_EXT_PRIO: s_nxt.ext_prio = s_r.wdata[4:0];
					OFF_EXT_FLAG: s_nxt.ext_flag = s_r.wdata[7:4];
					OFF_TMR_CTL: s_nxt.tmr_ctl = s_r.wdata;
					OFF_EXT_IRQ_CTL: begin
						s_nxt.aux_gate = s_r.wdata[AUX_GATE_BIT];
						s_nxt.aux_flag = s_r.wdata[AUX_FLAG_BIT];
						s_nxt.wdt_flag = s_r.wdata[WDT_FLAG_BIT];
					end
					OFF_AUX_ENABLE: s_nxt.aux_en = s_r.wdata;
					default: s_nxt.bp_en = s_r.wdata[BP_ENABLE_BIT];
				endcase
			end
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd_val;
			s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end

		// return from service drops the highest active level first
		if (core_done) begin
			if (s_r.in_service[2]) begin
				s_nxt.in_service[2] = 1'b0;
			end else if (s_r.in_service[1]) begin
				s_nxt.in_service[1] = 1'b0;
			end else begin
				s_nxt.in_service[0] = 1'b0;
			end
		end
		if (ack_now) begin
			s_nxt.in_service[s_r.core.level] = 1'b1;
			unique case (s_r.sel)
				// [R8] edge-mode flag cleared on vector
				IDX_EXT0: begin
					if (s_r.tmr_ctl[EXT0_MODE_BIT]) begin
						s_nxt.tmr_ctl[EXT0_FLAG_BIT] = 1'b0;
					end
				end
				IDX_EXT1: begin
					if (s_r.tmr_ctl[EXT1_MODE_BIT]) begin
						s_nxt.tmr_ctl[EXT1_FLAG_BIT] = 1'b0;
					end
				end
				// [R9] timer flags cleared on vector
				IDX_TMR0: s_nxt.tmr_ctl[TMR0_FLAG_BIT] = 1'b0;
				IDX_TMR1: s_nxt.tmr_ctl[TMR1_FLAG_BIT] = 1'b0;
				default: ;
			endcase
		end

		// hardware sets come last so an event beats a same-cycle clear
		s_nxt.pin_prev = pins;
		// [R8] edge sets, level tracks pin
		if (s_r.tmr_ctl[EXT0_MODE_BIT]) begin
			s_nxt.tmr_ctl[EXT0_FLAG_BIT] = s_nxt.tmr_ctl[EXT0_FLAG_BIT] | rise[0];
		end else begin
			s_nxt.tmr_ctl[EXT0_FLAG_BIT] = src.ext_lvl_pin[0];
		end
		if (s_r.tmr_ctl[EXT1_MODE_BIT]) begin
			s_nxt.tmr_ctl[EXT1_FLAG_BIT] = s_nxt.tmr_ctl[EXT1_FLAG_BIT] | rise[1];
		end else begin
			s_nxt.tmr_ctl[EXT1_FLAG_BIT] = src.ext_lvl_pin[1];
		end
		s_nxt.tmr_ctl[TMR0_FLAG_BIT] = s_nxt.tmr_ctl[TMR0_FLAG_BIT] | src.tmr0_ovf;
		s_nxt.tmr_ctl[TMR1_FLAG_BIT] = s_nxt.tmr_ctl[TMR1_FLAG_BIT] | src.tmr1_ovf;
		// [R2] external 2 to 5 flags
		s_nxt.ext_flag = s_nxt.ext_flag | rise[5:2];
		s_nxt.wdt_flag = s_nxt.wdt_flag | src.wdt_evt;
		// [R4] [R5] enabled auxiliary events
		s_nxt.aux_flag = s_nxt.aux_flag | (|(src.aux_evt & s_r.aux_en)) |
			(src.bp_evt & s_r.bp_en);

		// presented vector; one idle cycle after a take lets flags settle
		s_nxt.core.req = cand_v & ~blocked & ~ack_now;
		s_nxt.core.level = cand_lvl;
		s_nxt.sel = cand_idx;
		if (cand_idx == IDX_AUX) begin
			// [R3] shared vector
			s_nxt.core.vector = AUX_VECTOR;
		end else begin
			// [R7] [R10] standard vector table
			s_nxt.core.vector = STD_VECTOR[cand_idx];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.irq_en <= RST_IRQ_ENABLE;
			s_r.prio <= RST_PRIO_SELECT;
			s_r.ext_en <= RST_EXT_ENABLE;
			s_r.ext_prio <= RST_EXT_PRIO;
			s_r.tmr_ctl <= RST_TMR_CTL;
			s_r.aux_en <= RST_AUX_ENABLE;
			s_r.core.level <= LVL_LOW;
			s_r.bresp <= RESP_OKAY;
			s_r.rresp <= RESP_OKAY;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

endmodule
`default_nettype wire

/* tlic_pkg.sv */
// Purpose: shared constants and carrier types of the three-level
//          interrupt controller
// Assumes: 8-bit control registers, one per aligned 32-bit bus word
// Notes:   offsets are byte addresses on the register bus
package tlic_pkg;

	localparam int AXI_AW = 8;

	// register byte offsets
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] OFF_PRIO_SELECT = 8'h04;
	localparam logic [7:0] OFF_EXT_ENABLE = 8'h08;
	localparam logic [7:0] OFF_EXT_PRIO = 8'h0C;
	localparam logic [7:0] OFF_EXT_FLAG = 8'h10;
	localparam logic [7:0] OFF_TMR_CTL = 8'h14;
	localparam logic [7:0] OFF_EXT_IRQ_CTL = 8'h18;
	localparam logic [7:0] OFF_AUX_ENABLE = 8'h1C;
	localparam logic [7:0] OFF_BP_CTL = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;

	// reset values
	localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
	localparam logic [6:0] RST_PRIO_SELECT = 7'h00;
	localparam logic [4:0] RST_EXT_ENABLE = 5'h00;
	localparam logic [4:0] RST_EXT_PRIO = 5'h00;
	localparam logic [7:0] RST_TMR_CTL = 8'h00;
	localparam logic [7:0] RST_AUX_ENABLE = 8'h00;
	// extended flag register: bit 3 always reads one
	localparam logic [7:0] EXT_FLAG_FIXED = 8'h08;

	// field positions
	localparam int GLOBAL_GATE_BIT = 7;
	localparam int EXT0_MODE_BIT = 0;
	localparam int EXT0_FLAG_BIT = 1;
	localparam int EXT1_MODE_BIT = 2;
	localparam int EXT1_FLAG_BIT = 3;
	localparam int TMR0_FLAG_BIT = 5;
	localparam int TMR1_FLAG_BIT = 7;
	localparam int EXT_FLAG_LSB = 4;
	localparam int WDT_FLAG_BIT = 3;
	localparam int AUX_FLAG_BIT = 4;
	localparam int AUX_GATE_BIT = 5;
	localparam int BP_ENABLE_BIT = 0;
	localparam int STATUS_REQ_BIT = 7;

	// vectors: standard sources in polling order, then the shared one
	localparam int NUM_STD = 12;
	localparam logic [NUM_STD-1:0][7:0] STD_VECTOR = {
		8'h63, 8'h5B, 8'h53, 8'h4B, 8'h43, 8'h3B,
		8'h2B, 8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03};
	localparam logic [7:0] AUX_VECTOR = 8'h33;
	localparam logic [3:0] AUX_NUMBER = 4'h6;
	localparam logic [3:0] IDX_EXT0 = 4'h0;
	localparam logic [3:0] IDX_TMR0 = 4'h1;
	localparam logic [3:0] IDX_EXT1 = 4'h2;
	localparam logic [3:0] IDX_TMR1 = 4'h3;
	localparam logic [3:0] IDX_AUX = 4'hC;

	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_HIGH = 2'h1,
		LVL_AUX = 2'h2
	} tlic_level_type;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] ext_lvl_pin;
		logic [3:0] ext_edge_pin;
		logic tmr0_ovf;
		logic tmr1_ovf;
		logic tmr2_flag;
		logic ser0_flag;
		logic ser1_flag;
		logic wdt_evt;
		logic [7:0] aux_evt;
		logic bp_evt;
	} tlic_src_type;

	typedef struct packed {
		logic req;
		tlic_level_type level;
		logic [7:0] vector;
	} tlic_core_type;

endpackage

/* tlic_core_model.sv */
// Purpose: core stand-in that fetches vectors
// Assumes: one service at a time, no nesting
// Notes:   slow delays the ack, so req must hold
`timescale 1ns/1ns
`default_nettype none
module tlic_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire tlic_pkg::tlic_core_type core,
	input wire logic [3:0] slow,
	output logic core_ack,
	output logic core_done,
	output tlic_pkg::tlic_core_type got,
	output logic [7:0] cnt
);
	import tlic_pkg::*;
	logic busy;
	logic [3:0] w;
	always @(posedge aclk) begin
		core_ack <= 1'h0;
		core_done <= 1'h0;
		if (core_ack && core.req) begin
			got <= core;
			cnt <= cnt + 8'h01;
		end
		if (!aresetn) begin
			busy <= 1'h0;
			w <= 4'h0;
			cnt <= 8'h00;
		end else if (busy) begin
			w <= w + 4'h1;
			// quick return keeps levels re-arbitrating
			if (w == 4'h3) begin
				core_done <= 1'h1;
				busy <= 1'h0;
				w <= 4'h0;
			end
		end else if (core.req && !core_ack) begin
			w <= w + 4'h1;
			if (w >= slow) begin
				core_ack <= 1'h1;
				busy <= 1'h1;
				w <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

/* tlic_ctrl_monitor.sv */
// Purpose: port checks of the interrupt controller
// Assumes: ce held high
// Notes:   bound into tlic_ctrl
`timescale 1ns/1ns
`default_nettype none
module tlic_ctrl_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire tlic_pkg::tlic_core_type core,
	input wire logic core_ack
);
	import tlic_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_take;
		core.req && core_ack;
	endsequence
	sequence s_ar;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_take_drop: assert property (s_take |=> !core.req)
		else $error("req stayed up after ack");
	a_aux_vector: assert property (core.req && core.level == LVL_AUX
		|-> core.vector == AUX_VECTOR) else $error("aux vector wrong");
	a_std_vector: assert property (core.req && core.level != LVL_AUX
		|-> core.vector[2:0] == 3'h3 && core.vector != AUX_VECTOR
		&& core.vector <= 8'h63) else $error("standard vector wrong");
	a_read_lat: assert property (s_ar |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	a_rd_upper: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
		else $error("read lanes or ready wrong");
	a_reset_idle: assert property (disable iff (1'h0) !aresetn
		|=> !core.req && !s_axi_bvalid && !s_axi_rvalid)
		else $error("not idle after reset");
endmodule
bind tlic_ctrl tlic_ctrl_monitor tlic_ctrl_monitor_i (.aclk, .aresetn,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.core, .core_ack);
`default_nettype wire

/* test_three_level_interrupt_controller.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: ce high, one-lane register writes
// Notes:   event sources pulse one cycle on src; serial flags and level pins are held
`timescale 1ns/1ns
`default_nettype none
module test_three_level_interrupt_controller;
	import tlic_pkg::*;
	localparam tlic_src_type M_T0 = '{tmr0_ovf: 1'h1, default: '0};
	localparam tlic_src_type M_T1 = '{tmr1_ovf: 1'h1, default: '0};
	localparam tlic_src_type M_BP = '{bp_evt: 1'h1, default: '0};
	localparam tlic_src_type M_E2 = '{ext_edge_pin: 4'h1, default: '0};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] aw = 8'h00, ar = 8'h00, d, cnt;
	logic [31:0] wd = 32'h0, rdata;
	logic awv = 1'h0, wv = 1'h0, arv = 1'h0, bready = 1'h0, rready = 1'h0;
	logic [3:0] slow = 4'h0;
	logic [3:0] strb = 4'h1;
	logic [1:0] resp, bresp, rresp;
	logic core_ack, core_done, awready, wready, bvalid, arready, rvalid;
	int fails = 0, compares = 0, cyc = 0;
	tlic_src_type src = '0;
	tlic_core_type core, got;
	tlic_ctrl tlic_ctrl_i (.aclk, .aresetn, .ce(1'h1), .s_axi_awaddr(aw),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wd),
		.s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .src, .core, .core_ack, .core_done);
	tlic_core_model tlic_core_model_i (.aclk, .aresetn, .core, .slow,
		.core_ack, .core_done, .got, .cnt);
	always #25 aclk = ~aclk;
	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			test_done;
		end
	end
	task automatic chk(input string n, input logic [7:0] e, s);
		compares++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		logic b_done;
		b_done = 1'h0;
		// idle edge first: back-to-back calls never drive a signal twice
		@(posedge aclk);
		aw <= a;
		wd <= {24'h0, v};
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		while (!b_done) begin
			@(posedge aclk);
			if (awv && awready) awv <= 1'h0;
			if (wv && wready) wv <= 1'h0;
			if (bready && bvalid) begin
				bready <= 1'h0;
				resp = bresp;
				b_done = 1'h1;
			end
		end
	endtask
	task automatic rdc(input logic [7:0] a, e, input string n);
		logic r_done;
		r_done = 1'h0;
		@(posedge aclk);
		ar <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		while (!r_done) begin
			@(posedge aclk);
			if (arv && arready) arv <= 1'h0;
			if (rready && rvalid) begin
				rready <= 1'h0;
				d = rdata[7:0];
				resp = rresp;
				r_done = 1'h1;
			end
		end
		chk(n, e, d);
	endtask
	task automatic pulse(input tlic_src_type m);
		src <= src | m;
		@(posedge aclk);
		src <= src & ~m;
	endtask
	task automatic take(input logic [7:0] e);
		logic [7:0] n0;
		n0 = cnt;
		while (cnt === n0) @(posedge aclk);
		chk("vector", e, got.vector);
	endtask
	task automatic none;
		logic [7:0] n0;
		n0 = cnt;
		repeat (12) @(posedge aclk);
		chk("take count", n0, cnt);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 10; i++)
			rdc(8'(i * 4), (i == 4) ? EXT_FLAG_FIXED : 8'h00, "reset");
		rdc(8'h30, 8'h00, "unmapped read");
		chk("unmapped rresp", {6'h0, RESP_SLVERR}, {6'h0, resp});
		wr(8'h30, 8'hFF);
		chk("unmapped bresp", {6'h0, RESP_SLVERR}, {6'h0, resp});
		// lane 0 strobe low: accepted but nothing changes
		strb <= 4'h0;
		wr(OFF_IRQ_ENABLE, 8'hFF);
		chk("masked bresp", {6'h0, RESP_OKAY}, {6'h0, resp});
		strb <= 4'h1;
		rdc(OFF_IRQ_ENABLE, 8'h00, "masked write");
		$display("done reset");
	endtask
	task automatic t_timer;
		wr(OFF_IRQ_ENABLE, 8'h02);
		pulse(M_T0);
		none;
		wr(OFF_IRQ_ENABLE, 8'h82);
		take(8'h0B);
		rdc(OFF_TMR_CTL, 8'h00, "timer flags");
		slow <= 4'h6;
		wr(OFF_IRQ_ENABLE, 8'h88);
		pulse(M_T1);
		take(8'h1B);
		rdc(OFF_TMR_CTL, 8'h00, "timer flags");
		slow <= 4'h0;
		wr(OFF_IRQ_ENABLE, 8'h00);
		$display("done timers");
	endtask
	task automatic t_prio;
		src.ser0_flag <= 1'h1;
		src.ser1_flag <= 1'h1;
		wr(OFF_IRQ_ENABLE, 8'hD0);
		take(8'h23);
		wr(OFF_IRQ_ENABLE, 8'h00);
		wr(OFF_PRIO_SELECT, 8'h40);
		wr(OFF_IRQ_ENABLE, 8'hD0);
		take(8'h3B);
		chk("level", 8'(LVL_HIGH), 8'(got.level));
		src.ser0_flag <= 1'h0;
		src.ser1_flag <= 1'h0;
		wr(OFF_IRQ_ENABLE, 8'h00);
		wr(OFF_PRIO_SELECT, 8'h00);
		$display("done priority");
	endtask
	task automatic t_aux;
		tlic_src_type m;
		for (int i = 0; i < 8; i++) begin
			m = '0;
			m.aux_evt = 8'h01 << ((i + 1) % 8);
			wr(OFF_AUX_ENABLE, 8'h01 << i);
			wr(OFF_EXT_IRQ_CTL, 8'h00);
			pulse(m);
			rdc(OFF_EXT_IRQ_CTL, 8'h00, "aux flag off");
			m.aux_evt = 8'h01 << i;
			pulse(m);
			rdc(OFF_EXT_IRQ_CTL, 8'h10, "aux flag on");
		end
		none;
		wr(OFF_AUX_ENABLE, 8'h00);
		wr(OFF_BP_CTL, 8'h01);
		wr(OFF_EXT_IRQ_CTL, 8'h20);
		pulse(M_BP);
		take(AUX_VECTOR);
		chk("aux level", 8'(LVL_AUX), 8'(got.level));
		rdc(OFF_EXT_IRQ_CTL, 8'h30, "aux flag");
		wr(OFF_EXT_IRQ_CTL, 8'h00);
		wr(OFF_BP_CTL, 8'h00);
		$display("done auxiliary");
	endtask
	task automatic t_ext;
		wr(OFF_EXT_ENABLE, 8'h01);
		wr(OFF_IRQ_ENABLE, 8'h80);
		pulse(M_E2);
		take(8'h43);
		rdc(OFF_EXT_FLAG, 8'h18, "ext2 flag");
		wr(OFF_EXT_FLAG, 8'h08);
		wr(OFF_IRQ_ENABLE, 8'h00);
		src.ext_lvl_pin[0] <= 1'h1;
		// flag follows the pin one cycle late
		@(posedge aclk);
		rdc(OFF_TMR_CTL, 8'h02, "level flag");
		src.ext_lvl_pin[0] <= 1'h0;
		@(posedge aclk);
		rdc(OFF_TMR_CTL, 8'h00, "level flag");
		wr(OFF_TMR_CTL, 8'h01);
		src.ext_lvl_pin[0] <= 1'h1;
		wr(OFF_IRQ_ENABLE, 8'h81);
		take(8'h03);
		rdc(OFF_TMR_CTL, 8'h01, "edge flag");
		src.ext_lvl_pin[0] <= 1'h0;
		wr(OFF_IRQ_ENABLE, 8'h00);
		$display("done external");
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset;
		t_timer;
		t_prio;
		t_aux;
		t_ext;
		test_done;
	end
endmodule
`default_nettype wire
